//--- verilog/rsw_rx_status.sv
// Receive status word builder and receiver start/stop/error control.
// Assumes the MAC receive path and the FIFOs run on i_clock; APB slave.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps

// Operation
// RL1 - Reserved status bits 31, 14, 9:8 and 0 always read zero.
// RL2 - Bit 30 set when frame failed the address filter.
// RL3 - Bits 29:16 carry the received frame byte count.
// RL4 - Bit 15 is OR of bits 11, 7, 6 and 1.
// RL5 - Bit 13 set for broadcast destination.
// RL6 - Bit 12 set when length field disagrees with measured length.
// RL7 - Bit 11 set when frame ends before 64 bytes.
// RL8 - Runts reach the host only when pass-bad-frames is set.
// RL9 - Bit 10 set for multicast destination.
// RL10 - Bit 7 set above 1518 bytes, frame not truncated.
// RL11 - Bit 6 set on collision after the collision window.
// RL12 - Bit 5 set when length/type above 1500, never under 14 bytes.
// RL13 - Bit 4 set when frame passes the watchdog limit.
// RL14 - Bit 3 set if receive error seen during frame.
// RL15 - Bit 2 on dribble bits 4 (MII) or 3+ (10M), not with late collision.
// RL16 - Bit 1 on CRC mismatch or receive error.
// RL17 - Host treats dribble without CRC error as valid.
// RL18 - Host stops reception by clearing receive enable.
// RL19 - One pulse on receive-stopped when receiver halts.
// RL20 - Host may flush FIFOs, then sets receive enable again.
// RL21 - Error flag on data underrun, status underrun or status overrun.
// RL22 - Receiver keeps running after the error flag rises.
// RL23 - Status word written only after frame data is in the data FIFO.
// RL24 - Host soft-resets after an underrun.
module rsw_rx_status (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_rx_dv,
  input  wire logic        i_rx_byte_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_er,
  input  wire logic        i_rx_col,
  input  wire logic        i_crc_ok,
  input  wire logic        i_filter_fail,
  input  wire logic [2:0]  i_dribble_bits,
  input  wire logic        i_mode_10m,
  input  wire logic        i_data_done,
  input  wire logic        i_data_underrun,
  input  wire logic        i_sts_underrun,
  input  wire logic        i_sts_full,
  output logic             o_rx_on,
  output logic             o_sts_wr,
  output logic      [31:0] o_sts_word,
  output logic             o_frame_drop,
  output logic             o_rx_stopped,
  output logic             o_rx_error
);

  rsw_pkg::rsw_state_t st_q;
  rsw_pkg::rsw_state_t st_d;
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [31:0] word_q;
  logic [31:0] sts_q;
  logic [13:0] cnt_q;
  logic [15:0] lt_q;
  logic        dv_q;
  logic        bcast_q;
  logic        mcast_q;
  logic        er_q;
  logic        lcol_q;
  logic        rx_on_q;
  logic        err_q;
  logic        wr_q;
  logic        drop_q;
  logic        stop_q;

  // APB decode
  wire         setup    = i_psel & ~i_penable;
  wire         access   = i_psel & i_penable;
  wire         hit_ctrl = i_paddr == rsw_pkg::CTRL_OFS;
  wire         hit_stat = i_paddr == rsw_pkg::STAT_OFS;
  wire         hit_last = i_paddr == rsw_pkg::LAST_OFS;
  wire         hit      = hit_ctrl | hit_stat | hit_last;
  wire         wr_ctrl  = access & i_pwrite & hit_ctrl;
  wire         wr_stat  = access & i_pwrite & hit_stat;
  wire [31:0]  stat_rd  = {30'h0, rx_on_q, err_q};
  wire [31:0]  rd_mux   = hit_ctrl ? ctrl_q :
                          hit_stat ? stat_rd :
                          hit_last ? word_q : 32'h0;

  wire         rx_en    = ctrl_q[rsw_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT];
  wire         pass_bad = ctrl_q[rsw_pkg::CTRL_PASS_BIT];

  // Frame framing: a frame only starts on a fresh rise of data valid, so
  // enabling mid-frame does not yield a truncated status word.
  wire         start    = (st_q == rsw_pkg::RSW_IDLE) & i_rx_dv & ~dv_q &
                          rx_on_q;
  wire         in_frame = (st_q == rsw_pkg::RSW_RECV) & i_rx_dv;
  wire         frm_end  = (st_q == rsw_pkg::RSW_RECV) & ~i_rx_dv;
  wire         take     = i_rx_byte_valid & (start | in_frame);
  wire [13:0]  cnt_base = start ? 14'h0 : cnt_q;
  wire [13:0]  cnt_inc  = cnt_base + 14'h1;
  wire         wdog_hit = cnt_q >= rsw_pkg::WDOG_LEN;
  wire         bc_first = start ? 1'b1 : bcast_q;
  wire         is_ff    = i_rx_byte == 8'hff;

  // End-of-frame status computation
  wire         runt     = cnt_q < rsw_pkg::RUNT_LEN;
  wire         ftype    = (cnt_q >= rsw_pkg::HDR_LEN) &
                          (lt_q > rsw_pkg::TYPE_MIN);
  wire [15:0]  lt_ovh   = lt_q + rsw_pkg::OVHD_LEN;
  wire [15:0]  exp_len  = (lt_ovh < rsw_pkg::MIN_FRAME) ?
                          rsw_pkg::MIN_FRAME : lt_ovh;
  wire         len_err  = (cnt_q >= rsw_pkg::HDR_LEN) &
                          (lt_q <= rsw_pkg::TYPE_MIN) &
                          ({2'b00, cnt_q} != exp_len);
  wire         drib_ok  = i_mode_10m ? (i_dribble_bits >= rsw_pkg::DRIB_10M)
                                     : (i_dribble_bits == rsw_pkg::DRIB_MII);
  wire         dribble  = drib_ok & ~lcol_q;
  wire         long_frm = cnt_q > rsw_pkg::MAX_LEN;
  wire         crc_err  = ~i_crc_ok | er_q;
  wire         err_sum  = runt | long_frm | lcol_q | crc_err;

  logic [31:0] sts_d;
  always_comb begin
    sts_d = 32'h0;
    sts_d[rsw_pkg::SW_FILT] = i_filter_fail;                 // see RL2
    sts_d[rsw_pkg::SW_LEN_L +: 14] = cnt_q;                  // see RL3
    sts_d[rsw_pkg::SW_ES] = err_sum;                         // see RL4
    sts_d[rsw_pkg::SW_BCAST] = bcast_q;                      // see RL5
    sts_d[rsw_pkg::SW_LENER] = len_err;                      // see RL6
    sts_d[rsw_pkg::SW_RUNT] = runt;                          // see RL7
    sts_d[rsw_pkg::SW_MCAST] = mcast_q & ~bcast_q;           // see RL9
    sts_d[rsw_pkg::SW_LONG] = long_frm;                      // see RL10
    sts_d[rsw_pkg::SW_LCOL] = lcol_q;                        // see RL11
    sts_d[rsw_pkg::SW_TYPE] = ftype;                         // see RL12
    sts_d[rsw_pkg::SW_WDOG] = wdog_hit;                      // see RL13
    sts_d[rsw_pkg::SW_MIIER] = er_q;                         // see RL14
    sts_d[rsw_pkg::SW_DRIB] = dribble;                       // see RL15
    sts_d[rsw_pkg::SW_CRC] = crc_err;                        // see RL16
    sts_d = sts_d & ~rsw_pkg::SW_RSVD_MASK;                  // see RL1
  end

  // Status hand-off waits for the data FIFO to hold the whole frame
  wire         done_ev  = (st_q == rsw_pkg::RSW_DONE) & i_data_done; // see RL23
  wire         keep     = ~sts_q[rsw_pkg::SW_RUNT] | pass_bad;       // see RL8
  wire         overrun  = done_ev & keep & i_sts_full;
  wire         err_set  = i_data_underrun | i_sts_underrun | overrun; // see RL21
  wire         err_clr  = wr_stat & i_pwdata[rsw_pkg::STAT_ERR_BIT];
  // Stop only between frames; a frame in flight finishes with its status.
  wire         halt     = ~rx_en & rx_on_q & (st_q == rsw_pkg::RSW_IDLE) &
                          ~start;

  always_comb begin
    case (st_q)
      rsw_pkg::RSW_IDLE: st_d = start ? rsw_pkg::RSW_RECV : rsw_pkg::RSW_IDLE;
      rsw_pkg::RSW_RECV: st_d = frm_end ? rsw_pkg::RSW_DONE : rsw_pkg::RSW_RECV;
      rsw_pkg::RSW_DONE: st_d = i_data_done ? rsw_pkg::RSW_IDLE
                                            : rsw_pkg::RSW_DONE;
      default:           st_d = rsw_pkg::RSW_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= rsw_pkg::RSW_IDLE;
      dv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      dv_q <= i_rx_dv;
    end
  end

  // Per-frame accumulators; counting runs past the length limits and holds at
  // 14'h3fff, so long frames are flagged but not truncated.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= 14'h0;
      lt_q    <= 16'h0;
      bcast_q <= 1'b0;
      mcast_q <= 1'b0;
    end else if (take) begin
      cnt_q <= (cnt_q == 14'h3fff && !start) ? cnt_q : cnt_inc; // see RL10
      if (cnt_base < 14'h6)
        bcast_q <= bc_first & is_ff;                        // see RL5
      if (cnt_base == 14'h0)
        mcast_q <= i_rx_byte[0];                            // see RL9
      if (cnt_base == 14'hc)
        lt_q <= {i_rx_byte, 8'h00};
      if (cnt_base == 14'hd)
        lt_q <= {lt_q[15:8], i_rx_byte};
    end else if (start) begin
      cnt_q   <= 14'h0;
      lt_q    <= 16'h0;
      bcast_q <= 1'b1;
      mcast_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      er_q   <= 1'b0;
      lcol_q <= 1'b0;
    end else if (start) begin
      er_q   <= i_rx_er;
      lcol_q <= 1'b0;
    end else if (in_frame) begin
      er_q   <= er_q | i_rx_er;                              // see RL14
      lcol_q <= lcol_q | (i_rx_col & ~runt);                 // see RL11
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sts_q  <= 32'h0;
      word_q <= 32'h0;
      wr_q   <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      if (frm_end)
        sts_q <= sts_d;
      if (done_ev && keep)
        word_q <= sts_q;
      wr_q   <= done_ev & keep;                              // see RL23
      drop_q <= done_ev & ~keep;                             // see RL8
    end
  end

  // Receiver on/off and the error flag; the flag never touches rx_on_q.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_on_q <= 1'b0;
      stop_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      if (rx_en)                                             // see RL22
        rx_on_q <= 1'b1;
      else if (halt)
        rx_on_q <= 1'b0;
      stop_q <= halt;                                        // see RL19
      err_q  <= err_set | (err_q & ~err_clr);                // see RL21
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q  <= rsw_pkg::CTRL_RST;
      rdata_q <= 32'h0;
    end else begin
      if (wr_ctrl)
        ctrl_q <= i_pwdata;
      // Read data captured in setup so the access phase needs no wait
      if (setup && !i_pwrite)
        rdata_q <= rd_mux;
    end
  end

  assign o_prdata     = rdata_q;
  assign o_pready     = 1'b1;
  assign o_pslverr    = access & ~hit;
  assign o_rx_on      = rx_on_q;
  assign o_sts_wr     = wr_q;
  assign o_sts_word   = word_q;
  assign o_frame_drop = drop_q;
  assign o_rx_stopped = stop_q;
  assign o_rx_error   = err_q;

  sequence s_wait_data;
    (st_q == rsw_pkg::RSW_DONE) && i_data_done;
  endsequence

  sequence s_frame_close;
    frm_end ##1 (st_q == rsw_pkg::RSW_DONE);
  endsequence

  property p_rsvd_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_sts_wr |-> ((o_sts_word & rsw_pkg::SW_RSVD_MASK) == 32'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // see RL1
    else $error("reserved status bit set");

  property p_err_sum;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_sts_wr |-> (o_sts_word[15] == (o_sts_word[11] | o_sts_word[7] |
                                       o_sts_word[6] | o_sts_word[1]));
  endproperty
  a_err_sum: assert property (p_err_sum) // see RL4
    else $error("error summary mismatch");

  property p_order;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_sts_wr |-> $past(st_q == rsw_pkg::RSW_DONE) && $past(i_data_done);
  endproperty
  a_order: assert property (p_order) // see RL23
    else $error("status written before frame data");

  property p_hand_off;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_frame_close ##[0:1000] s_wait_data |=> (o_sts_wr ^ o_frame_drop);
  endproperty
  a_hand_off: assert property (p_hand_off) // see RL23
    else $error("frame neither written nor dropped");

  property p_runt_drop;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_sts_wr && o_sts_word[11] |-> $past(pass_bad);
  endproperty
  a_runt_drop: assert property (p_runt_drop) // see RL8
    else $error("runt delivered without pass bad");

  property p_drib_col;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_sts_wr && o_sts_word[6] |-> !o_sts_word[2];
  endproperty
  a_drib_col: assert property (p_drib_col) // see RL15
    else $error("dribble with late collision");

  property p_type_runt;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_sts_wr && (o_sts_word[29:16] < 14'h000e) |-> !o_sts_word[5];
  endproperty
  a_type_runt: assert property (p_type_runt) // see RL12
    else $error("frame type on short runt");

  property p_stop_pulse;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_rx_stopped |-> !o_rx_on && $past(o_rx_on) ##1 !o_rx_stopped;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) // see RL19
    else $error("stop pulse not single or not on halt");

  property p_err_set;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_data_underrun || i_sts_underrun) |=> o_rx_error;
  endproperty
  a_err_set: assert property (p_err_set) // see RL21
    else $error("underrun did not raise error flag");

  property p_keep_running;
    @(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_rx_error) && $past(o_rx_on) && $past(rx_en) |-> o_rx_on;
  endproperty
  a_keep_running: assert property (p_keep_running) // see RL22
    else $error("receiver stopped by error flag");

  property p_keep_on;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_rx_on && rx_en |=> o_rx_on;
  endproperty
  a_keep_on: assert property (p_keep_on) // see RL22
    else $error("receiver dropped while enabled");

  property p_overrun;
    @(posedge i_clock) disable iff (!i_rst_n)
      done_ev && keep && i_sts_full |=> o_rx_error && o_sts_wr;
  endproperty
  a_overrun: assert property (p_overrun) // see RL21
    else $error("status overrun did not raise error flag");

  // Halting mid-frame would leave a frame without its status word
  property p_halt_idle;
    @(posedge i_clock) disable iff (!i_rst_n)
      $fell(o_rx_on) |-> $past(st_q == rsw_pkg::RSW_IDLE) && $rose(o_rx_stopped);
  endproperty
  a_halt_idle: assert property (p_halt_idle) // see RL19
    else $error("receiver halted outside idle or without pulse");

  property p_drop_single;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_frame_drop |=> !o_frame_drop && !o_sts_wr;
  endproperty
  a_drop_single: assert property (p_drop_single) // see RL8
    else $error("dropped frame reported twice");

endmodule // rsw_rx_status

//--- verilog/rsw_pkg.sv
// Constants for the receive status word and receiver control block.
// Assumes a single core clock shared with the MAC receive path.
package rsw_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] LAST_OFS = 8'h08;
  // Control register fields
  localparam int CTRL_RECEIVE_ENABLE_BIT_BIT  = 2;
  localparam int CTRL_PASS_BIT  = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Status register fields
  localparam int STAT_ERR_BIT   = 0;
  localparam int STAT_ON_BIT    = 1;
  // Status word fields
  localparam int SW_FILT  = 30;
  localparam int SW_LEN_L = 16;
  localparam int SW_ES    = 15;
  localparam int SW_BCAST = 13;
  localparam int SW_LENER = 12;
  localparam int SW_RUNT  = 11;
  localparam int SW_MCAST = 10;
  localparam int SW_LONG  = 7;
  localparam int SW_LCOL  = 6;
  localparam int SW_TYPE  = 5;
  localparam int SW_WDOG  = 4;
  localparam int SW_MIIER = 3;
  localparam int SW_DRIB  = 2;
  localparam int SW_CRC   = 1;
  localparam logic [31:0] SW_RSVD_MASK = 32'h8000_4301;
  // Frame length limits in bytes
  localparam logic [13:0] RUNT_LEN  = 14'h0040;
  localparam logic [13:0] MAX_LEN   = 14'h05ee;
  localparam logic [13:0] WDOG_LEN  = 14'h0800;
  localparam logic [13:0] HDR_LEN   = 14'h000e;
  localparam logic [15:0] TYPE_MIN  = 16'h05dc;
  localparam logic [15:0] OVHD_LEN  = 16'h0012;
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  // Dribble thresholds
  localparam logic [2:0] DRIB_MII = 3'h4;
  localparam logic [2:0] DRIB_10M = 3'h3;
  typedef enum logic [1:0] {
    RSW_IDLE = 2'b00,
    RSW_RECV = 2'b01,
    RSW_DONE = 2'b11
  } rsw_state_t;
endpackage

//--- test/rsw_data_fifo_model.sv
// Model of the receive data FIFO fill side: reports frame data landed.
// Assumes it shares i_clock with the block; the bench sets the delay.
`timescale 1ns/10ps
module rsw_data_fifo_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_rx_dv,
  input  wire logic [3:0] i_delay,
  output logic            o_data_done
);
  logic       dv_q;
  logic [4:0] cnt_q;

  // Data is only complete after the frame ends, so done never precedes it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dv_q <= 1'b0;
      cnt_q <= 5'h00;
      o_data_done <= 1'b0;
    end else begin
      dv_q <= i_rx_dv;
      o_data_done <= 1'b0;
      if (dv_q && !i_rx_dv) begin
        cnt_q <= {1'b1, i_delay};
      end else if (cnt_q[4] && cnt_q[3:0] == 4'h0) begin
        o_data_done <= 1'b1;
        cnt_q <= 5'h00;
      end else if (cnt_q[4]) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule // rsw_data_fifo_model

//--- test/rsw_rx_status_test.sv
// Self-checking bench: APB register access and receive frame traffic.
// Assumes the data FIFO model answers each frame end with a done pulse.
`timescale 1ns/10ps
module rsw_rx_status_test;
  localparam logic [31:0] EN = 32'h1 << rsw_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT;
  localparam logic [31:0] PB = 32'h1 << rsw_pkg::CTRL_PASS_BIT;
  logic        i_clock, i_rst_n, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr, i_rx_byte;
  logic [31:0] i_pwdata, o_prdata, o_sts_word, rd, last_exp;
  logic        o_pready, o_pslverr, i_rx_dv, i_rx_byte_valid, i_rx_er;
  logic        i_rx_col, i_crc_ok, i_filter_fail, i_mode_10m, i_data_done;
  logic [2:0]  i_dribble_bits;
  logic        i_data_underrun, i_sts_underrun, i_sts_full, o_rx_on;
  logic        o_sts_wr, o_frame_drop, o_rx_stopped, o_rx_error, err;
  logic        pass_bad;
  logic [3:0]  delay;
  int          fails, n_compared, n;

  rsw_rx_status rsw_rx_status_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_rx_dv(i_rx_dv),
    .i_rx_byte_valid(i_rx_byte_valid), .i_rx_byte(i_rx_byte),
    .i_rx_er(i_rx_er), .i_rx_col(i_rx_col), .i_crc_ok(i_crc_ok),
    .i_filter_fail(i_filter_fail), .i_dribble_bits(i_dribble_bits),
    .i_mode_10m(i_mode_10m), .i_data_done(i_data_done),
    .i_data_underrun(i_data_underrun), .i_sts_underrun(i_sts_underrun),
    .i_sts_full(i_sts_full), .o_rx_on(o_rx_on), .o_sts_wr(o_sts_wr),
    .o_sts_word(o_sts_word), .o_frame_drop(o_frame_drop),
    .o_rx_stopped(o_rx_stopped), .o_rx_error(o_rx_error));

  rsw_data_fifo_model rsw_data_fifo_model_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_rx_dv(i_rx_dv),
    .i_delay(delay), .o_data_done(i_data_done));

  always #5 i_clock = ~i_clock;

  task results;
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task timeout;
    fails++;
    $display("[FAIL] %0t wait ran out", $time);
    results();
  endtask

  task chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task chk_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Read data and slave error are taken at the edge that completes access
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (o_pready !== 1'b1) timeout();
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  function automatic logic [7:0] fbyte(input int i, input int kind,
                                       input logic [15:0] lt);
    if (i == 12) return lt[15:8];
    if (i == 13) return lt[7:0];
    if (i > 5) return i[7:0];
    if (kind == 1) return 8'hff;
    if (kind == 2) return (i == 0) ? 8'h01 : 8'h00;
    return 8'h02;
  endfunction

  task drive(input int len, input int kind, input logic [15:0] lt,
             input logic er, input int col);
    for (int i = 0; i < len; i++) begin
      @(posedge i_clock);
      i_rx_dv <= 1'b1;
      i_rx_byte_valid <= 1'b1;
      i_rx_byte <= fbyte(i, kind, lt);
      i_rx_er <= er && i == 3;
      i_rx_col <= col != 0 && i == col;
    end
    @(posedge i_clock);
    i_rx_dv <= 1'b0;
    i_rx_byte_valid <= 1'b0;
    i_rx_er <= 1'b0;
    i_rx_col <= 1'b0;
  endtask

  // kind: 0 unicast, 1 broadcast, 2 multicast; col is the collision byte
  task frame(input int len, input int kind, input logic [15:0] lt,
             input logic er, input int col, input logic crc,
             input logic flt, input logic [2:0] dr, input logic m10);
    logic [31:0] e;
    int          lim;
    int          k;
    lim = (lt + 18 < 64) ? 64 : lt + 18;
    e = 32'h0;
    e[29:16] = len[13:0];
    e[rsw_pkg::SW_FILT] = flt;
    e[rsw_pkg::SW_BCAST] = kind == 1;
    e[rsw_pkg::SW_MCAST] = kind == 2;
    e[rsw_pkg::SW_LENER] = lt <= 1500 && len >= 14 && len != lim;
    e[rsw_pkg::SW_RUNT] = len < 64;
    e[rsw_pkg::SW_LONG] = len > 1518;
    e[rsw_pkg::SW_LCOL] = col >= 64;
    e[rsw_pkg::SW_TYPE] = lt > 1500 && len >= 14;
    e[rsw_pkg::SW_WDOG] = len >= 2048;
    e[rsw_pkg::SW_MIIER] = er;
    e[rsw_pkg::SW_DRIB] = col < 64 && (m10 ? dr >= 3 : dr == 4);
    e[rsw_pkg::SW_CRC] = !crc || er;
    e[rsw_pkg::SW_ES] = e[11] | e[7] | e[6] | e[1];
    i_crc_ok <= crc;
    i_filter_fail <= flt;
    i_dribble_bits <= dr;
    i_mode_10m <= m10;
    drive(len, kind, lt, er, col);
    for (k = 0; k < 3000; k++) begin
      @(posedge i_clock);
      #1;
      if (o_sts_wr === 1'b1 || o_frame_drop === 1'b1) break;
    end
    if (k == 3000) timeout();
    chk_b(o_frame_drop, len < 64 && !pass_bad);
    if (o_frame_drop !== 1'b1) begin
      chk_w(o_sts_word, e);
      last_exp = e;
    end
  endtask

  initial begin
    {i_clock, i_rst_n, i_psel, i_penable, i_pwrite, i_rx_dv} = '0;
    {i_paddr, i_pwdata, i_rx_byte, i_rx_byte_valid, i_rx_er} = '0;
    {i_rx_col, i_crc_ok, i_filter_fail, i_dribble_bits} = '0;
    {i_mode_10m, i_data_underrun, i_sts_underrun, i_sts_full} = '0;
    {fails, n_compared, pass_bad, delay, last_exp} = '0;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    apb(0, rsw_pkg::CTRL_OFS, 0);
    chk_w(rd, rsw_pkg::CTRL_RST);
    apb(0, rsw_pkg::STAT_OFS, 0);
    chk_w(rd, 32'h0);
    apb(0, 8'h0c, 32'h0);
    chk_b(err, 1'b1);
    chk_w(rd, 32'h0);
    apb(1, rsw_pkg::CTRL_OFS, EN);
    frame(64, 1, 16'h0800, 0, 0, 1, 0, 0, 0);
    frame(100, 2, 16'h0052, 0, 0, 0, 0, 0, 0);
    frame(100, 0, 16'h002e, 0, 0, 1, 0, 0, 0);
    frame(20, 0, 16'h0800, 0, 0, 1, 0, 0, 0);
    apb(1, rsw_pkg::CTRL_OFS, EN | PB);
    pass_bad = 1'b1;
    delay = 4'h7;
    frame(20, 0, 16'h0800, 0, 0, 1, 0, 0, 0);
    frame(10, 1, 16'h0800, 0, 0, 1, 0, 0, 0);
    frame(1600, 0, 16'h0800, 0, 0, 1, 0, 0, 0);
    frame(2100, 0, 16'h0800, 0, 0, 1, 0, 0, 0);
    frame(100, 0, 16'h0052, 1, 0, 1, 0, 0, 0);
    frame(100, 0, 16'h0052, 0, 80, 1, 0, 3'h4, 0);
    frame(100, 0, 16'h0052, 0, 0, 1, 0, 3'h4, 0);
    frame(100, 0, 16'h0052, 0, 0, 1, 0, 3'h3, 0);
    frame(100, 0, 16'h0052, 0, 0, 1, 0, 3'h3, 1);
    frame(100, 0, 16'h0052, 0, 0, 1, 1, 0, 0);
    apb(0, rsw_pkg::LAST_OFS, 0);
    chk_w(rd, last_exp);
    apb(1, rsw_pkg::CTRL_OFS, 32'h0);
    for (n = 0; n < 20; n++) begin
      @(posedge i_clock);
      #1;
      if (o_rx_stopped === 1'b1) break;
    end
    if (n == 20) timeout();
    chk_b(o_rx_on, 1'b0);
    @(posedge i_clock);
    #1;
    chk_b(o_rx_stopped, 1'b0);
    drive(100, 0, 16'h0052, 0, 0);
    for (n = 0; n < 40; n++) begin
      @(posedge i_clock);
      #1;
      if (o_sts_wr === 1'b1) break;
    end
    chk_b(o_sts_wr, 1'b0);
    apb(1, rsw_pkg::CTRL_OFS, EN);
    frame(64, 0, 16'h0800, 0, 0, 1, 0, 0, 0);
    // Both underrun sources, each cleared by writing one to the flag
    for (n = 0; n < 2; n++) begin
      @(posedge i_clock);
      if (n == 0) i_data_underrun <= 1'b1;
      else i_sts_underrun <= 1'b1;
      @(posedge i_clock);
      i_data_underrun <= 1'b0;
      i_sts_underrun <= 1'b0;
      @(posedge i_clock);
      #1;
      chk_b(o_rx_error, 1'b1);
      apb(0, rsw_pkg::STAT_OFS, 0);
      chk_w(rd, 32'h3);
      apb(1, rsw_pkg::STAT_OFS, 32'h1);
      apb(0, rsw_pkg::STAT_OFS, 0);
      chk_w(rd, 32'h2);
    end
    // Host resynchronises with a soft reset after the underruns
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    pass_bad = 1'b0;
    apb(0, rsw_pkg::CTRL_OFS, 0);
    chk_w(rd, rsw_pkg::CTRL_RST);
    apb(0, rsw_pkg::STAT_OFS, 0);
    chk_w(rd, 32'h0);
    apb(1, rsw_pkg::CTRL_OFS, EN);
    i_sts_full <= 1'b1;
    frame(64, 0, 16'h0800, 0, 0, 1, 0, 0, 0);
    chk_b(o_rx_error, 1'b1);
    chk_b(o_rx_on, 1'b1);
    i_sts_full <= 1'b0;
    results();
  end
endmodule // rsw_rx_status_test
